// [rtl/bank_cmd_map.svh]
// bank_cmd_map.svh: numeric constants of the multibank command checker
// assumes it is included by bare name from the package and design file
`ifndef BANK_CMD_MAP_SVH
`define BANK_CMD_MAP_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS         50
`define PRECHARGE_TIME_NS       30
`define ACT_TO_COLUMN_DELAY_NS  30
`define WRITE_RECOVERY_TIME_NS  15
`define WRITE_TO_READ_CYC       2
`define SELFREFRESH_EXIT_NS     120
`define POWERDOWN_EXIT_NS       50
// least times round up to whole cycles, at least one
`define NS_TO_CYC(t) \
    ((((t) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS) < 1 ? 1 : \
     (((t) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS))

// ----------------------------------------------------------------
// command pin codes {ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define PINS_NOP        3'h7
`define PINS_ACTIVE     3'h3
`define PINS_READ       3'h5
`define PINS_WRITE      3'h4
`define PINS_PRECHARGE  3'h2
`define PINS_TERMINATE  3'h6
`define PINS_REFRESH    3'h1

// ----------------------------------------------------------------
// defaults
// ----------------------------------------------------------------
`define BURST_LEN_DEF           4
`define LATENCY_ROUNDED_UP_DEF  3

`endif

// [rtl/bank_cmd_pkg.sv]
// bank_cmd_pkg: types shared by the multibank command checker
// assumes bank_cmd_map.svh is on the include path
`include "bank_cmd_map.svh"
package bank_cmd_pkg;
    typedef enum logic [6:0] {
        BANK_IDLE       = 7'h01,
        BANK_ACTIVATING = 7'h02,
        BANK_ACTIVE     = 7'h04,
        BANK_READ       = 7'h08,
        BANK_WRITE      = 7'h10,
        BANK_AP_ACCESS  = 7'h20,
        BANK_PRECHARGE  = 7'h40
    } bank_state_e;

    typedef enum logic [5:0] {
        CMD_NONE      = 6'h01,
        CMD_ACTIVE    = 6'h02,
        CMD_READ      = 6'h04,
        CMD_WRITE     = 6'h08,
        CMD_PRECHARGE = 6'h10,
        CMD_OTHER     = 6'h20
    } command_e;
endpackage

// [rtl/multibank_command_legality.sv]
// multibank_command_legality: per-bank state tracker and alternate-bank
// command acceptance for a four-bank low-power dram command port
// assumes command pins come from the controller, asynchronous to clock_i
// assumes exit_pending_i stays high while an exit time still runs
// limitation: terminate, refresh and mode load are always refused
//
// Functional notes
// - chip select high is deselect, continue
// - all strobes high decodes no-operation
// - idle other bank accepts bank-legal command
// - row strobe alone decodes active
// - column strobe, write high decodes read
// - column strobe, write low decodes write
// - accept only with clock enable high twice
// - idle only after precharge time elapsed
// - row active after activate-to-column delay
// - read state until burst ends
// - write state until burst ends
// - read autoclose precharge starts after burst
// - write autoclose precharge after write recovery
// - access period runs until precharge starts
// - other banks accepted during autoclose access
// - row and write strobes decode precharge
`timescale 1ns/1ps
`default_nettype none
`include "bank_cmd_map.svh"

module multibank_command_legality #(
    parameter int BANKS              = 4,
    parameter int BURST_LEN          = `BURST_LEN_DEF,
    parameter int LATENCY_ROUNDED_UP = `LATENCY_ROUNDED_UP_DEF
) (
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 chip_sel_n_i,
    input  wire logic                 row_strobe_n_i,
    input  wire logic                 col_strobe_n_i,
    input  wire logic                 write_en_n_i,
    input  wire logic                 with_autoclose_i,
    input  wire logic [1:0]           bank_addr_i,
    input  wire logic                 exit_pending_i,
    output bank_cmd_pkg::command_e    command_o,
    output logic                      accepted_o,
    output logic                      illegal_o,
    output logic [BANKS-1:0]          bank_idle_o,
    output logic [BANKS-1:0]          bank_busy_o
);
    import bank_cmd_pkg::*;

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam int PRE_CYC = `NS_TO_CYC(`PRECHARGE_TIME_NS);
    localparam int ACT_CYC = `NS_TO_CYC(`ACT_TO_COLUMN_DELAY_NS);
    localparam int WR_CYC  = `NS_TO_CYC(`WRITE_RECOVERY_TIME_NS);
    // double rate: a burst fills half its length in clock cycles
    localparam int HALF_BL = BURST_LEN / 2;
    // eight timer bits cover every period at this clock rate
    localparam int CW      = 8;

    // ----------------------------------------------------------------
    // pin synchronisers: two flops before any decode
    // ----------------------------------------------------------------
    logic [8:0] pins_meta;
    logic [8:0] pins_sync;
    logic       clk_en_prev;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            // reset pattern reads as deselect with clock enable low
            pins_meta <= 9'h0f8;
            pins_sync <= 9'h0f8;
        end else begin
            pins_meta <= {clk_en_i, chip_sel_n_i, row_strobe_n_i,
                          col_strobe_n_i, write_en_n_i, with_autoclose_i,
                          bank_addr_i, exit_pending_i};
            pins_sync <= pins_meta;
        end
    end

    logic       s_cke;
    logic       s_cs_n;
    logic [2:0] s_pins;
    logic       s_ap;
    logic [1:0] s_bank;
    logic       s_exit;
    assign s_cke  = pins_sync[8];
    assign s_cs_n = pins_sync[7];
    assign s_pins = pins_sync[6:4];
    assign s_ap   = pins_sync[3];
    assign s_bank = pins_sync[2:1];
    assign s_exit = pins_sync[0];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            clk_en_prev <= 1'b0;
        end else begin
            clk_en_prev <= s_cke;
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    command_e next_cmd;
    logic     edge_valid;

    // exit times are still running while exit_pending is high
    assign edge_valid = clk_en_prev && s_cke && !s_exit;

    // terminate, refresh and mode load all fall to other
    always_comb begin
        next_cmd = CMD_NONE;
        if (s_cs_n) begin
            next_cmd = CMD_NONE;
        end else begin
            case (s_pins)
                `PINS_NOP:       next_cmd = CMD_NONE;
                `PINS_ACTIVE:    next_cmd = CMD_ACTIVE;
                `PINS_READ:      next_cmd = CMD_READ;
                `PINS_WRITE:     next_cmd = CMD_WRITE;
                `PINS_PRECHARGE: next_cmd = CMD_PRECHARGE;
                default:         next_cmd = CMD_OTHER;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // per-bank state and legality
    // ----------------------------------------------------------------
    bank_state_e      state [BANKS];
    logic [CW-1:0]    timer [BANKS];
    logic [BANKS-1:0] legal_here;
    logic [BANKS-1:0] hit;
    logic [BANKS-1:0] take;
    logic             legal;

    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            // the bank field is compared at its own width, so more than
            // four banks would need a wider address pin
            assign hit[b] = edge_valid && (s_bank == 2'(b));

            // target bank's own state decides; other banks never block
            always_comb begin
                legal_here[b] = 1'b0;
                case (state[b])
                    BANK_IDLE: begin
                        legal_here[b] = (next_cmd == CMD_ACTIVE) ||
                                        (next_cmd == CMD_PRECHARGE);
                    end
                    BANK_ACTIVE, BANK_READ, BANK_WRITE: begin
                        legal_here[b] = (next_cmd == CMD_READ) ||
                                        (next_cmd == CMD_WRITE) ||
                                        (next_cmd == CMD_PRECHARGE);
                    end
                    default: begin
                        legal_here[b] = 1'b0;
                    end
                endcase
            end

            assign take[b] = hit[b] && (next_cmd != CMD_NONE) &&
                             legal_here[b];

            // bank state: moves on a taken command or a spent timer
            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    state[b] <= BANK_IDLE;
                end else if (take[b]) begin
                    case (next_cmd)
                        CMD_ACTIVE: begin
                            state[b] <= BANK_ACTIVATING;
                        end
                        CMD_READ: begin
                            state[b] <= s_ap ? BANK_AP_ACCESS
                                             : BANK_READ;
                        end
                        CMD_WRITE: begin
                            state[b] <= s_ap ? BANK_AP_ACCESS
                                             : BANK_WRITE;
                        end
                        default: begin
                            state[b] <= BANK_PRECHARGE;
                        end
                    endcase
                end else if (timer[b] <= 8'h01) begin
                    case (state[b])
                        BANK_ACTIVATING: begin
                            state[b] <= BANK_ACTIVE;
                        end
                        BANK_READ, BANK_WRITE: begin
                            state[b] <= BANK_ACTIVE;
                        end
                        BANK_AP_ACCESS: begin
                            state[b] <= BANK_PRECHARGE;
                        end
                        BANK_PRECHARGE: begin
                            state[b] <= BANK_IDLE;
                        end
                        default: begin
                            state[b] <= state[b];
                        end
                    endcase
                end
            end

            // bank timer: loaded with the length of the period just begun
            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    timer[b] <= 8'h00;
                end else if (take[b]) begin
                    case (next_cmd)
                        CMD_ACTIVE: begin
                            timer[b] <= CW'(ACT_CYC);
                        end
                        CMD_READ: begin
                            // autoclose read: precharge begins where the
                            // earliest full-burst precharge would sit
                            timer[b] <= CW'(HALF_BL);
                        end
                        CMD_WRITE: begin
                            timer[b] <= s_ap
                                ? CW'(HALF_BL + 1 + WR_CYC)
                                : CW'(HALF_BL + 1);
                        end
                        default: begin
                            timer[b] <= CW'(PRE_CYC);
                        end
                    endcase
                end else if (timer[b] > 8'h01) begin
                    timer[b] <= timer[b] - 8'h01;
                end else if (state[b] == BANK_AP_ACCESS) begin
                    // access period over, the precharge period follows
                    timer[b] <= CW'(PRE_CYC);
                end else begin
                    timer[b] <= 8'h00;
                end
            end

            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    bank_idle_o[b] <= 1'b1;
                end else begin
                    bank_idle_o[b] <= (state[b] == BANK_IDLE);
                end
            end

            // busy covers every period that a same-bank command may not cut
            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    bank_busy_o[b] <= 1'b0;
                end else begin
                    bank_busy_o[b] <= (state[b] == BANK_AP_ACCESS) ||
                                      (state[b] == BANK_PRECHARGE) ||
                                      (state[b] == BANK_ACTIVATING);
                end
            end
        end
    endgenerate

    // any bank-legal command is taken even while other banks run an
    // autoclose access; timing spacing is the controller's job
    assign legal = legal_here[s_bank];

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            command_o <= CMD_NONE;
        end else begin
            command_o <= edge_valid ? next_cmd : CMD_NONE;
        end
    end

    // pulses last one cycle; a held command pin gives one pulse per edge
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            accepted_o <= 1'b0;
            illegal_o  <= 1'b0;
        end else begin
            accepted_o <= edge_valid && next_cmd != CMD_NONE && legal;
            illegal_o  <= edge_valid && next_cmd != CMD_NONE &&
                          !legal;
        end
    end
endmodule
`default_nettype wire

// [test/multibank_command_legality_sva.sv]
// checker: decode and bank-state relations at the ports
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bank_cmd_map.svh"
module multibank_command_legality_sva
    import bank_cmd_pkg::*;
#(parameter int BANKS = 4) (
    input wire logic             clock_i,
    input wire logic             reset_i,
    input wire logic             clk_en_i,
    input wire logic             chip_sel_n_i,
    input wire logic             row_strobe_n_i,
    input wire logic             col_strobe_n_i,
    input wire logic             write_en_n_i,
    input wire logic             exit_pending_i,
    input wire command_e         command_o,
    input wire logic             accepted_o,
    input wire logic             illegal_o,
    input wire logic [BANKS-1:0] bank_idle_o,
    input wire logic [BANKS-1:0] bank_busy_o
);
    import bank_cmd_pkg::*;
    // ------
    // decode timing: answer three edges after the pins
    // ------
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_take(logic [2:0] p);
        clk_en_i && $past(clk_en_i) && !chip_sel_n_i &&
        {row_strobe_n_i, col_strobe_n_i, write_en_n_i} == p;
    endsequence
    sequence s_quiet;
        !exit_pending_i [*3];
    endsequence
    property p_dec(logic [2:0] p, command_e c);
        s_take(p) ##0 s_quiet |=> command_o == c;
    endproperty
    a_deselect_no_pulse: assert property (chip_sel_n_i |-> ##3
        (command_o == CMD_NONE && !accepted_o && !illegal_o))
        else $error("deselect produced a command");
    a_nop_is_none: assert property (p_dec(`PINS_NOP, CMD_NONE))
        else $error("nop not decoded as none");
    a_active_decode: assert property (p_dec(`PINS_ACTIVE, CMD_ACTIVE))
        else $error("active misdecoded");
    a_read_decode: assert property (p_dec(`PINS_READ, CMD_READ))
        else $error("read misdecoded");
    a_write_decode: assert property (p_dec(`PINS_WRITE, CMD_WRITE))
        else $error("write misdecoded");
    a_pre_decode: assert property (
        p_dec(`PINS_PRECHARGE, CMD_PRECHARGE))
        else $error("precharge misdecoded");
    a_cke_low_blocks: assert property (!clk_en_i |-> ##3 !accepted_o)
        else $error("command taken with clock enable low");
    a_idle_after_busy: assert property (
        (bank_idle_o & ~$past(bank_idle_o) & ~$past(bank_busy_o)) == '0)
        else $error("bank idle without precharge period");
endmodule
`default_nettype wire

// [test/ctl_model.sv]
// controller model: drives one command per call on the pins
// assumes caller keeps bank-legal order and spacing
`timescale 1ns/1ps
`default_nettype none
`include "bank_cmd_map.svh"
module ctl_model (
    input  wire logic       clock_i,
    output logic            cs_n_o,
    output logic [2:0]      pins_o,
    output logic [1:0]      bank_o,
    output logic            ap_o
);
    // ------
    // command driver
    // ------
    initial begin
        cs_n_o = 1'b1;
        pins_o = `PINS_NOP;
        bank_o = 2'h0;
        ap_o = 1'b0;
    end
    // no write data is driven, so no read cuts a write needing data_mask
    // two-cycle slot is shorter than the auto-close read-to-write gap of burst_len 4
    task automatic issue(input logic c, input logic [2:0] p,
                         input logic [1:0] b, input logic a);
        @(negedge clock_i);
        cs_n_o = c;
        pins_o = p;
        bank_o = b;
        ap_o = a;
        @(negedge clock_i);
        cs_n_o = 1'b1;
        pins_o = `PINS_NOP;
        // stale qualifiers are not held after the command
        bank_o = ~b;
        ap_o = ~a;
    endtask
endmodule
`default_nettype wire

// [test/multibank_command_legality_tb_top.sv]
// bench top: directed scenarios against the legality tracker
// assumes the design answers three edges after the pins
`timescale 1ns/1ps
`default_nettype none
`include "bank_cmd_map.svh"
module multibank_command_legality_tb_top;
    import bank_cmd_pkg::*;
    // ------
    // harness
    // ------
    logic clock_i, reset_i, clk_en, exit_pend;
    logic cs_n, ap;
    logic [2:0] pins;
    logic [1:0] bank;
    command_e command_o;
    logic accepted_o, illegal_o;
    logic [3:0] bank_idle_o, bank_busy_o;
    int err_count = 0, total_checks = 0, cycles = 0;
    // least gap from a read with autoclose to a write on another bank
    localparam int RD_TO_WR = `LATENCY_ROUNDED_UP_DEF + `BURST_LEN_DEF / 2;
    ctl_model ctl (.clock_i(clock_i), .cs_n_o(cs_n), .pins_o(pins),
        .bank_o(bank), .ap_o(ap));
    multibank_command_legality DUT (.clock_i(clock_i), .reset_i(reset_i),
        .clk_en_i(clk_en), .chip_sel_n_i(cs_n), .row_strobe_n_i(pins[2]),
        .col_strobe_n_i(pins[1]), .write_en_n_i(pins[0]),
        .with_autoclose_i(ap), .bank_addr_i(bank),
        .exit_pending_i(exit_pend), .command_o(command_o),
        .accepted_o(accepted_o), .illegal_o(illegal_o),
        .bank_idle_o(bank_idle_o), .bank_busy_o(bank_busy_o));
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic c, input logic [2:0] p, input logic [1:0] b,
                       input logic a, input command_e e, input logic [1:0] r);
        ctl.issue(c, p, b, a);
        repeat (2) @(posedge clock_i);
        #1;
        check(8'(command_o), 8'(e));
        check({6'h0, accepted_o, illegal_o}, {6'h0, r});
    endtask
    task automatic t_basic;
        check({bank_idle_o, bank_busy_o}, 8'hf0);
        cmd(0, `PINS_ACTIVE, 0, 0, CMD_ACTIVE, 2'h2);
        cmd(0, `PINS_READ, 0, 0, CMD_READ, 2'h2);
        cmd(0, `PINS_WRITE, 0, 0, CMD_WRITE, 2'h2);
        cmd(0, `PINS_PRECHARGE, 0, 0, CMD_PRECHARGE, 2'h2);
        repeat (3) @(posedge clock_i);
        #1 check(8'(bank_idle_o), 8'h0f);
    endtask
    task automatic t_refuse;
        cmd(1, `PINS_ACTIVE, 1, 0, CMD_NONE, 2'h0);
        cmd(0, `PINS_NOP, 1, 0, CMD_NONE, 2'h0);
        cmd(0, `PINS_READ, 2, 0, CMD_READ, 2'h1);
        cmd(0, `PINS_TERMINATE, 2, 0, CMD_OTHER, 2'h1);
        cmd(0, `PINS_REFRESH, 2, 0, CMD_OTHER, 2'h1);
        check(8'(bank_idle_o), 8'h0f);
    endtask
    task automatic t_gate(input logic k, input logic x);
        @(negedge clock_i);
        clk_en = k;
        exit_pend = x;
        ctl.issue(0, `PINS_ACTIVE, 3, 0);
        repeat (2) @(posedge clock_i);
        #1 check({7'h0, accepted_o}, 8'h0);
        @(negedge clock_i);
        clk_en = 1'b1;
        exit_pend = 1'b0;
        repeat (3) @(negedge clock_i);
        check(8'(bank_idle_o), 8'h0f);
    endtask
    task automatic t_autoclose;
        cmd(0, `PINS_ACTIVE, 1, 0, CMD_ACTIVE, 2'h2);
        cmd(0, `PINS_ACTIVE, 0, 0, CMD_ACTIVE, 2'h2);
        ctl.issue(0, `PINS_READ, 0, 1);
        ctl.issue(0, `PINS_READ, 1, 0);
        repeat (2) @(posedge clock_i);
        #1 check({7'h0, accepted_o}, 8'h1);
        repeat (RD_TO_WR + 3) @(posedge clock_i);
        #1 check(8'(bank_idle_o), 8'h0d);
        ctl.issue(0, `PINS_WRITE, 1, 1);
        cmd(0, `PINS_ACTIVE, 0, 0, CMD_ACTIVE, 2'h2);
        cmd(0, `PINS_PRECHARGE, 0, 0, CMD_PRECHARGE, 2'h2);
        repeat (4) @(posedge clock_i);
        #1 check(8'(bank_idle_o), 8'h0f);
    endtask
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        reset_i = 1'b1;
        clk_en = 1'b1;
        exit_pend = 1'b0;
        repeat (2) @(negedge clock_i);
        reset_i = 1'b0;
        repeat (2) @(negedge clock_i);
        t_basic();
        t_refuse();
        t_gate(1'b0, 1'b0);
        t_gate(1'b1, 1'b1);
        t_autoclose();
        finish_test();
    end
endmodule
bind multibank_command_legality multibank_command_legality_sva #(
    .BANKS(BANKS)) chk (.clock_i(clock_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .chip_sel_n_i(chip_sel_n_i),
    .row_strobe_n_i(row_strobe_n_i), .col_strobe_n_i(col_strobe_n_i),
    .write_en_n_i(write_en_n_i), .exit_pending_i(exit_pending_i),
    .command_o(command_o), .accepted_o(accepted_o), .illegal_o(illegal_o),
    .bank_idle_o(bank_idle_o), .bank_busy_o(bank_busy_o));
`default_nettype wire
